// *** serial_timer_pkg.sv ***
/*
 * Shared constants for the serial port and its baud-capable 16-bit timer:
 * register addresses, bit positions, reset values, divider counts, states.
 * Assumes a byte-wide register port addressed by the 8-bit register number.
 */
package serial_timer_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  // ==========================================================================
  // Serial control bits
  localparam int MODE_BIT_HIGH = 7;
  localparam int MODE_BIT_LOW = 6;
  localparam int MULTIPROCESSOR_ENABLE = 5;
  localparam int RECEIVE_ENABLE = 4;
  localparam int TRANSMIT_NINTH_BIT = 3;
  localparam int RECEIVED_NINTH_BIT = 2;
  localparam int TRANSMIT_DONE_FLAG = 1;
  localparam int RECEIVE_DONE_FLAG = 0;
  // ==========================================================================
  // Timer control bits, and the clock control fast-timer bit
  localparam int TIMER_OVERFLOW_FLAG = 7;
  localparam int EXTERNAL_EVENT_FLAG = 6;
  localparam int RECEIVE_BAUD_SELECT = 5;
  localparam int TRANSMIT_BAUD_SELECT = 4;
  localparam int EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int TIMER_RUN_BIT = 2;
  localparam int COUNTER_TIMER_SELECT = 1;
  localparam int CAPTURE_RELOAD_SELECT = 0;
  localparam int TIMER_FAST_CLOCK = 5;
  // ==========================================================================
  // Reset values and the count maximum
  localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SERIAL_BUFFER_RESET = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
  localparam logic [15:0] CAPTURE_RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // ==========================================================================
  // Divider counts in clock cycles, sample points in 16x ticks, frame bit counts
  localparam logic [3:0] SLOW_DIV = 4'hc;
  localparam logic [3:0] FAST_DIV = 4'h4;
  localparam logic [3:0] BAUDGEN_DIV = 4'h2;
  localparam logic [3:0] MODE2_FAST_DIV = 4'h2;
  localparam logic [3:0] MODE2_SLOW_DIV = 4'h4;
  localparam logic [3:0] MACHINE_CYCLE = 4'h4;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_SECOND = 4'h8;
  localparam logic [3:0] SAMPLE_THIRD = 4'h9;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] FRAME10_BITS = 4'ha;
  localparam logic [3:0] FRAME11_BITS = 4'hb;
  localparam logic [3:0] RX_LAST_10 = 4'h9;
  localparam logic [3:0] RX_LAST_11 = 4'ha;
  // ==========================================================================
  // States
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT, TX_SYNC} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_ASYNC, RX_SYNC, RX_SYNC_WAIT} rx_state_t;
endpackage : serial_timer_pkg

// *** two_entry_buffer.sv ***
/*
 * Two-entry first-in first-out buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 9
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic [1:0] fill_q;
  logic push;
  logic pop;

  assign in_ready_out = (fill_q != 2'h2);
  assign out_valid_out = (fill_q != 2'h0);
  assign out_data_out = head_q;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // ==========================================================================
  // Storage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fill_q <= 2'h0;
      head_q <= '0;
      tail_q <= '0;
    end else begin
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
      if (pop) begin
        head_q <= (fill_q == 2'h2) ? tail_q : in_data_in;
      end else if (push && fill_q == 2'h0) begin
        head_q <= in_data_in;
      end
      if (push && (fill_q == 2'h2 || (fill_q == 2'h1 && !pop))) begin
        tail_q <= in_data_in;
      end
    end
  end
endmodule : two_entry_buffer
`default_nettype wire

// *** serial_port_with_timer_baud.sv ***
/*
 * Four-mode serial port with the 16-bit general timer that can serve as its
 * baud source, reached through the byte-wide special-register port.
 * Assumes all pins synchronous to clk_in; timer 1 overflow arrives as a pulse.
 */
// Functional notes
// - Timer advances on clk/4 or clk/12, or count-pin falling edges, when running.
// - Counter or capture overflow sets overflow flag and pulses output one cycle.
// - Capture: trigger falling edge with enable copies count into capture registers.
// - Reload mode: overflow sets flag and loads count from capture/reload registers.
// - Reload mode: enabled trigger falling edge forces an immediate reload.
// - Either baud select forces auto-reload; each overflow gives one 16x baud tick.
// - Baud generator mode never sets overflow flag; trigger still sets event flag.
// - Baud generator counts clk/2, or count-pin edges when counter select set.
// - Received words are held so another word can arrive before reading.
// - Top two serial control bits select modes 0 to 3.
// - Mode 0 sync 8 bits; modes 1-3 framed, mode 2 at clk/32 or /64.
// - Modes 2 and 3 with multiprocessor enable drop frames with ninth bit 0.
// - Mode 1 with multiprocessor enable accepts only a stop bit of one.
// - Mode 0 shift rate is clk/12, or clk/4 with multiprocessor enable.
// - Reception starts only while receive enable is set.
// - Transmit ninth bit supplies the ninth bit sent in modes 2 and 3.
// - Received ninth bit holds ninth bit in modes 2/3, stop bit in mode 1.
// - Mode 0 data on receive pin, shift clock on transmit pin.
// - Mode 0 buffer write shifts eight bits out LSB first.
// - Mode 0 receive starts with enable and flag clear, sets flag, then halts.
// - Async receiver oversamples 16x, resyncs on start, votes three middle samples.
// - Timer overflow baud source is divided by 16; timer 1 overflow by 32 when smod_in is low.
// - Transmit starts after first divide-by-16 rollover; start, data, stop.
`timescale 1ns/10ps
`default_nettype none
module serial_port_with_timer_baud (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic smod_in,
  input wire logic timer1_overflow_in,
  input wire logic count_input_pin_in,
  input wire logic external_trigger_pin_in,
  output logic overflow_pulse_out,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_out,
  output logic txd_out
);
  function automatic logic [3:0] div_next(input logic [3:0] q, input logic [3:0] lim);
    return (q >= lim - 4'h1) ? 4'h0 : q + 4'h1;
  endfunction : div_next

  function automatic logic div_wrap(input logic [3:0] q, input logic [3:0] lim);
    return q >= lim - 4'h1;
  endfunction : div_wrap

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // ==========================================================================
  // Register state
  logic [7:0] sc_q, sc_d, hold_q, tc_q, tc_d, ck_q;
  logic [15:0] cap_q, cap_d, cnt_q, cnt_d, cnt_hw;
  logic [7:0] rdata_q, rd_mux;
  logic wr_sc, wr_serial_buffer, wr_tc, wr_ck, wr_capl, wr_caph, wr_cntl, wr_cnth;

  assign wr_sc = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_SERIAL_CONTROL);
  assign wr_serial_buffer = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_SERIAL_BUFFER);
  assign wr_tc = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_TIMER_CONTROL);
  assign wr_ck = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_CLOCK_CONTROL);
  assign wr_capl = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_CAPTURE_RELOAD_LOW);
  assign wr_caph = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_CAPTURE_RELOAD_HIGH);
  assign wr_cntl = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_COUNT_LOW);
  assign wr_cnth = sfr_wr_in & (sfr_addr_in == serial_timer_pkg::ADDR_COUNT_HIGH);

  // ==========================================================================
  // Timer
  logic baud_mode, capture_sel, run, ext_en, tmr_wrap, timer_tick, overflow;
  logic cpin_prev_q, trig_prev_q, trig_ev, cnt_reload, pulse_q;
  logic [3:0] tmr_div_q, tmr_lim;

  assign baud_mode = tc_q[serial_timer_pkg::RECEIVE_BAUD_SELECT]
                   | tc_q[serial_timer_pkg::TRANSMIT_BAUD_SELECT];
  assign capture_sel = tc_q[serial_timer_pkg::CAPTURE_RELOAD_SELECT] & ~baud_mode;
  assign run = tc_q[serial_timer_pkg::TIMER_RUN_BIT];
  assign ext_en = tc_q[serial_timer_pkg::EXTERNAL_TRIGGER_ENABLE];
  assign tmr_lim = baud_mode ? serial_timer_pkg::BAUDGEN_DIV
                 : (ck_q[serial_timer_pkg::TIMER_FAST_CLOCK] ? serial_timer_pkg::FAST_DIV
                   : serial_timer_pkg::SLOW_DIV);
  assign tmr_wrap = div_wrap(tmr_div_q, tmr_lim);
  assign timer_tick = run & (tc_q[serial_timer_pkg::COUNTER_TIMER_SELECT]
                             ? (cpin_prev_q & ~count_input_pin_in) : tmr_wrap);
  assign overflow = timer_tick & (cnt_q == serial_timer_pkg::COUNT_MAX);
  assign trig_ev = trig_prev_q & ~external_trigger_pin_in & ext_en;
  // Overflow reloads unless capturing; the trigger reloads only outside baud mode.
  assign cnt_reload = (overflow & ~capture_sel)
                    | (trig_ev & ~baud_mode & ~capture_sel);
  assign cnt_hw = cnt_reload ? cap_q : (timer_tick ? cnt_q + 16'h0001 : cnt_q);
  assign cnt_d = wr_cntl ? {cnt_hw[15:8], sfr_wdata_in}
               : (wr_cnth ? {sfr_wdata_in, cnt_hw[7:0]} : cnt_hw);
  assign cap_d = (trig_ev & capture_sel) ? cnt_q
               : (wr_capl ? {cap_q[15:8], sfr_wdata_in}
               : (wr_caph ? {sfr_wdata_in, cap_q[7:0]} : cap_q));

  always_comb begin
    tc_d = wr_tc ? sfr_wdata_in : tc_q;
    if (overflow && !baud_mode) begin
      tc_d[serial_timer_pkg::TIMER_OVERFLOW_FLAG] = 1'b1;
    end
    if (trig_ev) begin
      tc_d[serial_timer_pkg::EXTERNAL_EVENT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tmr_div_q <= 4'h0;
      cpin_prev_q <= 1'b1;
      trig_prev_q <= 1'b1;
      pulse_q <= 1'b0;
    end else begin
      tmr_div_q <= div_next(tmr_div_q, tmr_lim);
      cpin_prev_q <= count_input_pin_in;
      trig_prev_q <= external_trigger_pin_in;
      pulse_q <= overflow & ~baud_mode;
    end
  end
  assign overflow_pulse_out = pulse_q;

  // ==========================================================================
  // Baud ticks at sixteen times the bit rate
  logic is_m0, is_m1, is_m2, sm2, t1_half_q, t1_eff, t2_baud, m2_wrap, tx_x16, rx_x16;
  logic [3:0] m2_div_q, m2_lim;

  assign is_m0 = ~sc_q[serial_timer_pkg::MODE_BIT_HIGH] & ~sc_q[serial_timer_pkg::MODE_BIT_LOW];
  assign is_m1 = ~sc_q[serial_timer_pkg::MODE_BIT_HIGH] & sc_q[serial_timer_pkg::MODE_BIT_LOW];
  assign is_m2 = sc_q[serial_timer_pkg::MODE_BIT_HIGH] & ~sc_q[serial_timer_pkg::MODE_BIT_LOW];
  assign sm2 = sc_q[serial_timer_pkg::MULTIPROCESSOR_ENABLE];
  assign t1_eff = timer1_overflow_in & (smod_in | t1_half_q);
  assign t2_baud = overflow & baud_mode;
  assign m2_lim = smod_in ? serial_timer_pkg::MODE2_FAST_DIV : serial_timer_pkg::MODE2_SLOW_DIV;
  assign m2_wrap = div_wrap(m2_div_q, m2_lim);
  assign tx_x16 = is_m2 ? m2_wrap
                : (tc_q[serial_timer_pkg::TRANSMIT_BAUD_SELECT] ? t2_baud : t1_eff);
  assign rx_x16 = is_m2 ? m2_wrap
                : (tc_q[serial_timer_pkg::RECEIVE_BAUD_SELECT] ? t2_baud : t1_eff);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      m2_div_q <= 4'h0;
      t1_half_q <= 1'b0;
    end else begin
      m2_div_q <= div_next(m2_div_q, m2_lim);
      t1_half_q <= t1_half_q ^ timer1_overflow_in;
    end
  end

  // ==========================================================================
  // Mode 0 shift clock
  logic [3:0] m0_div_q, m0_lim, m0_half;
  logic m0_active, m0_wrap, m0_rise;
  serial_timer_pkg::tx_state_t tx_state_q;
  serial_timer_pkg::rx_state_t rx_state_q;

  assign m0_lim = sm2 ? serial_timer_pkg::FAST_DIV : serial_timer_pkg::SLOW_DIV;
  assign m0_half = m0_lim >> 1;
  assign m0_active = (tx_state_q == serial_timer_pkg::TX_SYNC)
                   | (rx_state_q == serial_timer_pkg::RX_SYNC);
  assign m0_wrap = m0_active & div_wrap(m0_div_q, m0_lim);
  assign m0_rise = m0_active & (m0_div_q == m0_half);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      m0_div_q <= 4'h0;
    end else begin
      m0_div_q <= m0_active ? div_next(m0_div_q, m0_lim) : 4'h0;
    end
  end

  // ==========================================================================
  // Transmitter
  logic [10:0] tx_shift_q;
  logic [3:0] tx_bits_q, tx_cnt_q;
  logic txd_q, tx_roll, tx_async, ti_set;

  assign tx_roll = tx_x16 & (tx_cnt_q == serial_timer_pkg::OVERSAMPLE_LAST);
  assign tx_async = (tx_state_q == serial_timer_pkg::TX_WAIT)
                  | (tx_state_q == serial_timer_pkg::TX_SHIFT);
  assign ti_set = (tx_async & tx_roll & (tx_bits_q == 4'h1))
                | ((tx_state_q == serial_timer_pkg::TX_SYNC) & m0_wrap & (tx_bits_q == 4'h1));

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_state_q <= serial_timer_pkg::TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      txd_q <= 1'b1;
    end else begin
      if (tx_x16) begin
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      if (wr_serial_buffer && is_m0) begin
        tx_state_q <= serial_timer_pkg::TX_SYNC;
        tx_shift_q <= {3'h7, sfr_wdata_in};
        tx_bits_q <= serial_timer_pkg::SYNC_BITS;
      end else if (wr_serial_buffer) begin
        tx_state_q <= serial_timer_pkg::TX_WAIT;
        tx_shift_q <= {1'b1, is_m1 | sc_q[serial_timer_pkg::TRANSMIT_NINTH_BIT],
                       sfr_wdata_in, 1'b0};
        tx_bits_q <= is_m1 ? serial_timer_pkg::FRAME10_BITS : serial_timer_pkg::FRAME11_BITS;
      end else if (tx_state_q == serial_timer_pkg::TX_SYNC && m0_wrap) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1) begin
          tx_state_q <= serial_timer_pkg::TX_IDLE;
        end
      end else if (tx_async && tx_roll) begin
        if (tx_bits_q == 4'h0) begin
          tx_state_q <= serial_timer_pkg::TX_IDLE;
        end else begin
          tx_state_q <= serial_timer_pkg::TX_SHIFT;
          txd_q <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_bits_q <= tx_bits_q - 4'h1;
        end
      end
    end
  end

  // Without open drain, rxd is only driven while a mode 0 word goes out.
  assign rxd_out = tx_shift_q[0];
  assign rxd_oe_out = (tx_state_q == serial_timer_pkg::TX_SYNC);
  assign txd_out = is_m0 ? (~m0_active | (m0_div_q >= m0_half)) : txd_q;

  // ==========================================================================
  // Receiver
  logic [9:0] rx_shift_q, rx_full;
  logic [3:0] rx_cnt_q, rx_bits_q;
  logic [1:0] samp_q;
  logic rxd_prev_q, rx_bit, rx_decide, rx_last, async_done, sync_done, ren, ri;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [8:0] rx_word, buf_in_data, buf_out_data;

  assign ren = sc_q[serial_timer_pkg::RECEIVE_ENABLE];
  assign ri = sc_q[serial_timer_pkg::RECEIVE_DONE_FLAG];
  assign rx_bit = maj3(samp_q[1], samp_q[0], rxd_in);
  assign rx_decide = (rx_state_q == serial_timer_pkg::RX_ASYNC) & rx_x16
                   & (rx_cnt_q == serial_timer_pkg::SAMPLE_THIRD);
  assign rx_last = rx_bits_q == (is_m1 ? serial_timer_pkg::RX_LAST_10
                                       : serial_timer_pkg::RX_LAST_11);
  assign rx_full = {rx_bit, rx_shift_q[9:1]};
  assign rx_word = is_m1 ? rx_full[9:1] : rx_full[8:0];
  assign async_done = rx_decide & rx_last;
  assign sync_done = (rx_state_q == serial_timer_pkg::RX_SYNC_WAIT)
                   & (rx_cnt_q == serial_timer_pkg::MACHINE_CYCLE - 4'h1);
  // A word with a failed address or stop check never enters the buffer.
  assign buf_in_valid = (async_done & (~sm2 | rx_word[8])) | sync_done;
  assign buf_in_data = sync_done ? {sc_q[serial_timer_pkg::RECEIVED_NINTH_BIT], rx_shift_q[9:2]}
                                 : rx_word;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rx_state_q <= serial_timer_pkg::RX_IDLE;
      rx_shift_q <= 10'h000;
      rx_cnt_q <= 4'h0;
      rx_bits_q <= 4'h0;
      samp_q <= 2'h3;
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= rxd_in;
      unique case (rx_state_q)
        serial_timer_pkg::RX_IDLE: begin
          if (is_m0 && ren && !ri && buf_in_ready && !buf_out_valid
              && tx_state_q == serial_timer_pkg::TX_IDLE) begin
            rx_state_q <= serial_timer_pkg::RX_SYNC;
            rx_bits_q <= 4'h0;
          end else if (!is_m0 && ren && rxd_prev_q && !rxd_in) begin
            rx_state_q <= serial_timer_pkg::RX_ASYNC;
            rx_cnt_q <= 4'h0;
            rx_bits_q <= 4'h0;
          end
        end
        serial_timer_pkg::RX_ASYNC: begin
          if (rx_x16) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
          if (rx_x16 && (rx_cnt_q == serial_timer_pkg::SAMPLE_FIRST
                         || rx_cnt_q == serial_timer_pkg::SAMPLE_SECOND)) begin
            samp_q <= {samp_q[0], rxd_in};
          end
          if (rx_decide) begin
            rx_shift_q <= rx_full;
            rx_bits_q <= rx_bits_q + 4'h1;
            if ((rx_bits_q == 4'h0 && rx_bit) || rx_last) begin
              rx_state_q <= serial_timer_pkg::RX_IDLE;
            end
          end
        end
        serial_timer_pkg::RX_SYNC: begin
          if (m0_rise) begin
            rx_shift_q <= {rxd_in, rx_shift_q[9:1]};
          end
          if (m0_wrap) begin
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == serial_timer_pkg::SYNC_BITS - 4'h1) begin
              rx_state_q <= serial_timer_pkg::RX_SYNC_WAIT;
              rx_cnt_q <= 4'h0;
            end
          end
        end
        serial_timer_pkg::RX_SYNC_WAIT: begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (sync_done) begin
            rx_state_q <= serial_timer_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // A full buffer drops the arriving word rather than stalling the line.
  two_entry_buffer #(.WIDTH(9)) rx_buffer (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(buf_in_valid),
    .in_ready_out(buf_in_ready),
    .in_data_in(buf_in_data),
    .out_valid_out(buf_out_valid),
    .out_ready_in(~ri),
    .out_data_out(buf_out_data)
  );

  assign buf_pop = buf_out_valid & ~ri;

  // ==========================================================================
  // Serial control and holding register
  always_comb begin
    sc_d = wr_sc ? sfr_wdata_in : sc_q;
    if (ti_set) begin
      sc_d[serial_timer_pkg::TRANSMIT_DONE_FLAG] = 1'b1;
    end
    if (buf_pop) begin
      sc_d[serial_timer_pkg::RECEIVE_DONE_FLAG] = 1'b1;
      sc_d[serial_timer_pkg::RECEIVED_NINTH_BIT] = buf_out_data[8];
    end
  end

  always_comb begin
    unique case (sfr_addr_in)
      serial_timer_pkg::ADDR_SERIAL_CONTROL: rd_mux = sc_q;
      serial_timer_pkg::ADDR_SERIAL_BUFFER: rd_mux = hold_q;
      serial_timer_pkg::ADDR_TIMER_CONTROL: rd_mux = tc_q;
      serial_timer_pkg::ADDR_CLOCK_CONTROL: rd_mux = ck_q;
      serial_timer_pkg::ADDR_CAPTURE_RELOAD_LOW: rd_mux = cap_q[7:0];
      serial_timer_pkg::ADDR_CAPTURE_RELOAD_HIGH: rd_mux = cap_q[15:8];
      serial_timer_pkg::ADDR_COUNT_LOW: rd_mux = cnt_q[7:0];
      serial_timer_pkg::ADDR_COUNT_HIGH: rd_mux = cnt_q[15:8];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sc_q <= serial_timer_pkg::SERIAL_CONTROL_RESET;
      hold_q <= serial_timer_pkg::SERIAL_BUFFER_RESET;
      tc_q <= serial_timer_pkg::TIMER_CONTROL_RESET;
      ck_q <= serial_timer_pkg::CLOCK_CONTROL_RESET;
      cap_q <= serial_timer_pkg::CAPTURE_RELOAD_RESET;
      cnt_q <= serial_timer_pkg::COUNT_RESET;
      rdata_q <= 8'h00;
    end else begin
      sc_q <= sc_d;
      tc_q <= tc_d;
      cap_q <= cap_d;
      cnt_q <= cnt_d;
      if (wr_ck) begin
        ck_q <= sfr_wdata_in;
      end
      if (buf_pop) begin
        hold_q <= buf_out_data[7:0];
      end
      if (sfr_rd_in) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign sfr_rdata_out = rdata_q;
endmodule : serial_port_with_timer_baud
`default_nettype wire

// *** serial_asserts.sv ***
/* Checker for the serial port's register port, timer pulse and mode 0 pins.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module serial_asserts (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic overflow_pulse_out,
  input wire logic rxd_out,
  input wire logic rxd_oe_out,
  input wire logic txd_out
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_cap_wr; sfr_wr_in && sfr_addr_in == 8'hca; endsequence
  sequence s_cap_rd; !sfr_wr_in && sfr_rd_in && sfr_addr_in == 8'hca; endsequence
  a_pulse_one_cycle: assert property (overflow_pulse_out |=> !overflow_pulse_out)
    else $error("overflow pulse longer than one cycle");
  a_cap_readback: assert property (s_cap_wr ##1 !sfr_wr_in ##1 s_cap_rd
    |=> sfr_rdata_out == $past(sfr_wdata_in, 3))
    else $error("capture low read back differs");
  a_oe_from_write: assert property ($rose(rxd_oe_out)
    |-> $past(sfr_wr_in && sfr_addr_in == 8'h99))
    else $error("shift out began without a buffer write");
  a_first_half_low: assert property ($rose(rxd_oe_out) |-> !txd_out)
    else $error("shift clock not low at first bit");
  a_oe_spans_bits: assert property ($rose(rxd_oe_out) |-> rxd_oe_out [*8])
    else $error("shift out ended early");
  a_clk_low_half: assert property (rxd_oe_out && $fell(txd_out) |=> !txd_out)
    else $error("shift clock low phase too short");
  a_data_on_fall: assert property (rxd_oe_out && $past(rxd_oe_out) && $changed(rxd_out)
    |-> $fell(txd_out))
    else $error("shift data moved off the clock fall");
  a_idle_clock_high: assert property ($fell(rxd_oe_out) |-> txd_out)
    else $error("shift clock not high after the last bit");
endmodule : serial_asserts
bind serial_port_with_timer_baud serial_asserts chk (.*);
`default_nettype wire

// *** serial_peer.sv ***
/* Serial peer on the receive pin.
   Assumes the bench enables the echo only in the framed modes. */
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic clk_in,
  input wire logic loop_in,
  input wire logic txd_in,
  output logic rxd_out
);
  // ==========================================================================
  // A released line rests at the pull-up level rather than the last bit.
  always_ff @(posedge clk_in) begin
    rxd_out <= loop_in ? txd_in : 1'b1;
  end
endmodule : serial_peer
`default_nettype wire

// *** tb.sv ***
/* Testbench for the serial port with its timer.
   Assumes the checker is bound in and the peer echoes the transmit pin. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_in = 0, nrst_in = 0, wr = 0, rd = 0, loop = 0, trig = 1;
  logic [7:0] addr = 0, wdata = 0, rdata, v;
  logic ovf, pin_out, pin_oe, txd, peer_rxd;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  wire line = pin_oe ? pin_out : peer_rxd;
  always #4 clk_in = ~clk_in;
  serial_port_with_timer_baud dut (.clk_in(clk_in), .nrst_in(nrst_in), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .smod_in(1'b1),
    .timer1_overflow_in(1'b0), .count_input_pin_in(1'b1), .external_trigger_pin_in(trig),
    .overflow_pulse_out(ovf), .rxd_in(line), .rxd_out(pin_out), .rxd_oe_out(pin_oe), .txd_out(txd));
  serial_peer peer (.clk_in(clk_in), .loop_in(loop), .txd_in(txd), .rxd_out(peer_rxd));
  // ==========================================================================
  // Bus tasks, entered and left at a falling edge.
  task automatic wr_reg(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk_in) wr = 0;
    @(negedge clk_in);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1;
    @(negedge clk_in) rd = 0;
    d = rdata;
    @(negedge clk_in);
  endtask : rd_reg
  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd_chk(input string n, input logic [7:0] a, e);
    rd_reg(a, v);
    chk(n, e, v);
  endtask : rd_chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  always @(posedge clk_in) if (++cyc == 20000) begin
    error_cnt++;
    end_sim();
  end
  // ==========================================================================
  // Scenarios.
  task automatic t_timer;
    wr_reg(8'hcb, 8'h12);
    wr_reg(8'hca, 8'h34);
    rd_chk("capture low", 8'hca, 8'h34);
    rd_chk("unmapped", 8'h00, 8'h00);
    wr_reg(8'hcd, 8'hff);
    wr_reg(8'hcc, 8'hfd);
    wr_reg(8'h8e, 8'h20);
    wr_reg(8'hc8, 8'h04);
    for (int i = 0; i < 64 && ovf !== 1'b1; i++) @(negedge clk_in);
    chk("overflow pulse", 8'h01, {7'h0, ovf});
    rd_chk("overflow flag", 8'hc8, 8'h84);
    rd_chk("reload high", 8'hcd, 8'h12);
    wr_reg(8'hc8, 8'h09);
    wr_reg(8'hcc, 8'h56);
    trig = 0;
    @(negedge clk_in);
    rd_chk("capture", 8'hca, 8'h56);
    rd_chk("event flag", 8'hc8, 8'h49);
    trig = 1;
    wr_reg(8'hc8, 8'h00);
    $display("timer test done");
  endtask : t_timer
  task automatic t_mode0;
    wr_reg(8'h98, 8'h20);
    wr_reg(8'h99, 8'ha5);
    @(negedge clk_in);
    for (int b = 0; b < 8; b++) begin
      chk("shift bit", {7'h0, 1'(8'ha5 >> b)}, {7'h0, pin_out});
      repeat (4) @(negedge clk_in);
    end
    repeat (4) @(negedge clk_in);
    rd_chk("mode 0 done", 8'h98, 8'h22);
    wr_reg(8'h98, 8'h00);
    wr_reg(8'h98, 8'h30);
    repeat (40) @(negedge clk_in);
    rd_chk("mode 0 word", 8'h99, 8'hff);
    rd_chk("mode 0 flag", 8'h98, 8'h31);
    repeat (40) @(negedge clk_in);
    wr_reg(8'h98, 8'h00);
    rd_chk("mode 0 halted", 8'h98, 8'h00);
    $display("mode 0 test done");
  endtask : t_mode0
  task automatic send(input logic [7:0] d);
    wr_reg(8'h99, d);
    v = 0;
    for (int i = 0; i < 400 && v[1] !== 1'b1; i++) rd_reg(8'h98, v);
    repeat (80) @(negedge clk_in);
    rd_reg(8'h98, v);
    chk("transmit done", 8'h02, v & 8'h02);
    wr_reg(8'h98, v & 8'hfd);
  endtask : send
  task automatic t_mode2;
    loop = 1;
    wr_reg(8'h98, 8'h98);
    send(8'h3c);
    send(8'hc3);
    rd_chk("first word", 8'h99, 8'h3c);
    rd_reg(8'h98, v);
    chk("ninth bit", 8'h04, v & 8'h04);
    wr_reg(8'h98, v & 8'hfe);
    repeat (4) @(negedge clk_in);
    rd_chk("second ready", 8'h98, 8'h9d);
    rd_chk("second word", 8'h99, 8'hc3);
    $display("mode 2 test done");
  endtask : t_mode2
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1;
    rd_chk("control reset", 8'h98, 8'h00);
    t_timer();
    t_mode0();
    t_mode2();
    end_sim();
  end
endmodule : tb
`default_nettype wire
